/* common/pim_defs.vh */
// Constants shared by the pattern integrity monitor.
// Notes on behaviour
// - One generator and checker per channel.
// - Pattern block plus minimal encoding format logic.
// - Raw pattern only, no protocol framing.
// - Combined match true only when all match.
// - Sticky error set when combined match falls, except while the reset sequence runs.
// - Active-high one-bit clear input clears sticky.
// - Live match and sticky in bring-up domain.
// - Reset request starts full reset sequence.
// - Bring-up clock globally buffered, drives controller.
// - Unused core ports tied to defaults.
// - Some core ports driven locally, others passed.
// - Wrapper ports not used by helpers pass unchanged.
// - One reference clock buffer per source.
// - Source index 0 or 1 selects pair.
`ifndef PIM_DEFS_VH
`define PIM_DEFS_VH
`define PIM_NUM_CH 4
`define PIM_DATA_W 16
`define PIM_STATE_W 15
`define PIM_HDR_W 2
`define PIM_LOOPBACK_W 3
`define PIM_NUM_REFSRC 2
`define PIM_REFSRC_FIRST 1'b0
`define PIM_REFSRC_SECOND 1'b1
`define PIM_TAP_A 14
`define PIM_TAP_B 13
`define PIM_SEED 15'h7fff
`define PIM_HDR_DATA 2'h1
`define PIM_ENC_RAW 1'b0
`define PIM_ENC_GEARBOX 1'b1
`define PIM_LOOPBACK_OFF 3'h0
`define PIM_POLARITY_NORMAL 1'b0
`define PIM_CNT_W 5
// The reset sequence lasts 160 ns, counted here in 10 ns bring-up clock cycles at the counter's width.
`define PIM_RESET_SEQ_CYC 5'h10
`endif

/* hdl/pim_top.v */
// Pattern integrity monitor: per-channel pattern generators and checkers with combined status.
`timescale 1ns/100ps
`default_nettype none
`include "pim_defs.vh"

// One pattern block, configured as a generator or a checker.
module pim_prbs_lane #(
  parameter IS_CHECKER = 1'b0,
  parameter ENC_MODE = 1'b0
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  input wire hold_in,
  // Transmit side
  output reg [`PIM_DATA_W-1:0] tx_data_out,
  output reg [`PIM_HDR_W-1:0] tx_header_out,
  // Receive side
  input wire [`PIM_DATA_W-1:0] rx_data_in,
  input wire rx_valid_in,
  input wire [`PIM_HDR_W-1:0] rx_header_in,
  output reg match_out
);

  reg [`PIM_STATE_W-1:0] state_q;
  reg [`PIM_STATE_W-1:0] state_d;
  reg primed_q;
  wire [`PIM_DATA_W-1:0] next_word;
  wire hdr_ok;

  // Sixteen serial steps of the shift register; the last fifteen output bits become the new state.
  function [`PIM_DATA_W-1:0] pim_advance;
    input [`PIM_STATE_W-1:0] seed;
    reg [`PIM_STATE_W-1:0] s;
    reg b;
    integer i;
    begin
      s = seed;
      pim_advance = {`PIM_DATA_W{1'b0}};
      for (i = `PIM_DATA_W - 1; i >= 0; i = i - 1) begin
        b = s[`PIM_TAP_A] ^ s[`PIM_TAP_B];
        pim_advance[i] = b;
        s = {s[`PIM_STATE_W-2:0], b};
      end
    end
  endfunction

  assign next_word = pim_advance(state_q);
  // In gearbox format the header must mark a data block; raw format ignores it.
  assign hdr_ok = (ENC_MODE == `PIM_ENC_GEARBOX) ? (rx_header_in == `PIM_HDR_DATA) : 1'b1;

  always @* begin
    state_d = state_q;
    if (IS_CHECKER) begin
      if (rx_valid_in) begin
        state_d = rx_data_in[`PIM_STATE_W-1:0];
      end
    end else begin
      state_d = next_word[`PIM_STATE_W-1:0];
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= `PIM_SEED;
      primed_q <= 1'b0;
      match_out <= 1'b0;
      tx_data_out <= {`PIM_DATA_W{1'b0}};
      tx_header_out <= {`PIM_HDR_W{1'b0}};
    end else if (hold_in) begin
      state_q <= `PIM_SEED;
      primed_q <= 1'b0;
      match_out <= 1'b0;
      tx_data_out <= {`PIM_DATA_W{1'b0}};
      tx_header_out <= {`PIM_HDR_W{1'b0}};
    end else begin
      state_q <= state_d;
      if (IS_CHECKER) begin
        tx_data_out <= {`PIM_DATA_W{1'b0}};
        tx_header_out <= {`PIM_HDR_W{1'b0}};
        if (rx_valid_in) begin
          // The checker locks to the received stream, so the first word only seeds it.
          primed_q <= 1'b1;
          if (primed_q) begin
            match_out <= (rx_data_in == next_word) && hdr_ok;
          end
        end
      end else begin
        tx_data_out <= next_word;
        tx_header_out <= (ENC_MODE == `PIM_ENC_GEARBOX) ? `PIM_HDR_DATA : {`PIM_HDR_W{1'b0}};
        match_out <= 1'b0;
      end
    end
  end

endmodule // pim_prbs_lane

// Two flip-flop synchroniser for levels that enter the bring-up clock domain.
module pim_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Level from another domain and its re-timed copy
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // Only the second stage leaves this module, so a metastable first stage gets a whole cycle to settle.
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pim_sync2

// Top level of the demonstration design.
module pim_top #(
  parameter [`PIM_NUM_CH-1:0] ENC_MODE = {`PIM_NUM_CH{`PIM_ENC_RAW}},
  parameter [`PIM_NUM_CH-1:0] REFSRC_SEL = {`PIM_NUM_CH{`PIM_REFSRC_FIRST}}
) (
  // Free-running bring-up clock and power-on reset
  input wire clk_in,
  input wire rst_in,
  // Asynchronous operator inputs
  input wire full_system_reset_request_in,
  input wire error_clear_in,
  // Reference clock pairs, index 0 first source, index 1 second source
  input wire [`PIM_NUM_REFSRC-1:0] refclk_p_in,
  input wire [`PIM_NUM_REFSRC-1:0] refclk_n_in,
  output wire [`PIM_NUM_CH-1:0] chan_refclk_out,
  // Channel parallel data
  output wire [`PIM_NUM_CH*`PIM_DATA_W-1:0] tx_data_out,
  output wire [`PIM_NUM_CH*`PIM_HDR_W-1:0] tx_header_out,
  input wire [`PIM_NUM_CH*`PIM_DATA_W-1:0] rx_data_in,
  input wire [`PIM_NUM_CH*`PIM_HDR_W-1:0] rx_header_in,
  input wire [`PIM_NUM_CH-1:0] rx_valid_in,
  // Core control ports
  input wire core_reset_done_in,
  output wire core_reset_all_out,
  output wire core_userclk_active_out,
  output wire [`PIM_NUM_CH*`PIM_LOOPBACK_W-1:0] core_loopback_out,
  output wire [`PIM_NUM_CH-1:0] core_tx_polarity_out,
  output wire core_reset_done_out,
  // Status
  output reg match_all_out,
  output reg error_latched_out
);

  wire rst_req_sync;
  wire clr_sync;
  wire done_sync;
  wire [`PIM_NUM_CH-1:0] match_sync;
  reg [`PIM_CNT_W-1:0] seq_cnt_q;
  reg [`PIM_CNT_W-1:0] seq_cnt_d;
  reg seq_busy_q;
  reg userclk_active_q;
  wire [`PIM_NUM_CH-1:0] chan_match;
  wire [`PIM_NUM_REFSRC-1:0] refclk_buf;
  wire match_all_d;
  wire seq_start;

  // The clock port is the globally buffered bring-up clock; all logic here runs on it.

  // Differential reference buffers, one per configured source.
  genvar g;
  generate
    for (g = 0; g < `PIM_NUM_REFSRC; g = g + 1) begin : g_refbuf
      assign refclk_buf[g] = refclk_p_in[g] & ~refclk_n_in[g];
    end
    for (g = 0; g < `PIM_NUM_CH; g = g + 1) begin : g_chan
      // Each channel takes the first or the second source of its quad.
      assign chan_refclk_out[g] = (REFSRC_SEL[g] == `PIM_REFSRC_SECOND) ? refclk_buf[1] : refclk_buf[0];

      pim_prbs_lane #(
        .IS_CHECKER(1'b0),
        .ENC_MODE(ENC_MODE[g])
      ) u_stim (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .hold_in(seq_busy_q),
        .tx_data_out(tx_data_out[g*`PIM_DATA_W +: `PIM_DATA_W]),
        .tx_header_out(tx_header_out[g*`PIM_HDR_W +: `PIM_HDR_W]),
        .rx_data_in({`PIM_DATA_W{1'b0}}),
        .rx_valid_in(1'b0),
        .rx_header_in({`PIM_HDR_W{1'b0}}),
        .match_out()
      );

      pim_prbs_lane #(
        .IS_CHECKER(1'b1),
        .ENC_MODE(ENC_MODE[g])
      ) u_check (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .hold_in(seq_busy_q),
        .tx_data_out(),
        .tx_header_out(),
        .rx_data_in(rx_data_in[g*`PIM_DATA_W +: `PIM_DATA_W]),
        .rx_valid_in(rx_valid_in[g]),
        .rx_header_in(rx_header_in[g*`PIM_HDR_W +: `PIM_HDR_W]),
        .match_out(chan_match[g])
      );
    end
  endgenerate

  // Operator inputs, the core's done level and per-channel matches are re-timed before use.
  // The two-cycle latency is the price of a safe crossing; a bad word shows on the status three cycles late.
  pim_sync2 #(
    .WIDTH(1)
  ) u_sync_rst_req (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(full_system_reset_request_in),
    .sync_out(rst_req_sync)
  );

  pim_sync2 #(
    .WIDTH(1)
  ) u_sync_clr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(error_clear_in),
    .sync_out(clr_sync)
  );

  pim_sync2 #(
    .WIDTH(1)
  ) u_sync_done (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(core_reset_done_in),
    .sync_out(done_sync)
  );

  // Matches are re-timed per channel before the AND, so no channel is sampled mid-change.
  pim_sync2 #(
    .WIDTH(`PIM_NUM_CH)
  ) u_sync_match (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(chan_match),
    .sync_out(match_sync)
  );

  // Reset sequence: runs for a fixed time and holds the pattern logic while it is busy.
  // A request held high keeps restarting it, so the system stays in reset until release.
  assign seq_start = rst_req_sync;

  always @* begin
    seq_cnt_d = seq_cnt_q;
    if (seq_start) begin
      seq_cnt_d = `PIM_RESET_SEQ_CYC;
    end else if (seq_cnt_q != {`PIM_CNT_W{1'b0}}) begin
      seq_cnt_d = seq_cnt_q - 1'b1;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq_cnt_q <= `PIM_RESET_SEQ_CYC;
      seq_busy_q <= 1'b1;
      userclk_active_q <= 1'b0;
    end else begin
      seq_cnt_q <= seq_cnt_d;
      seq_busy_q <= (seq_cnt_d != {`PIM_CNT_W{1'b0}});
      // User clock networks are declared active once the sequence ends and the core reports done.
      userclk_active_q <= ~seq_busy_q & done_sync;
    end
  end

  assign core_reset_all_out = seq_busy_q;
  assign core_userclk_active_out = userclk_active_q;
  assign core_reset_done_out = done_sync;
  assign core_loopback_out = {`PIM_NUM_CH{`PIM_LOOPBACK_OFF}};
  assign core_tx_polarity_out = {`PIM_NUM_CH{`PIM_POLARITY_NORMAL}};

  assign match_all_d = &match_sync;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      match_all_out <= 1'b0;
      error_latched_out <= 1'b0;
    end else begin
      match_all_out <= match_all_d;
      // A falling combined match wins over a clear in the same cycle, so no error is lost.
      if (seq_busy_q) begin
        error_latched_out <= 1'b0;
      end else if (match_all_out & ~match_all_d) begin
        error_latched_out <= 1'b1;
      end else if (clr_sync) begin
        error_latched_out <= 1'b0;
      end
    end
  end

endmodule // pim_top
`default_nettype wire

/* dv/pim_top_assertions.sv */
// Concurrent checks on the ports of the pattern integrity monitor top level.
`timescale 1ns/100ps
`default_nettype none
module pim_top_assertions #(
  parameter [3:0] REFSRC_SEL = 4'h0
) (
  // Clock, reset and operator inputs
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic full_system_reset_request_in,
  input wire logic error_clear_in,
  // Reference clocks
  input wire logic [1:0] refclk_p_in,
  input wire logic [1:0] refclk_n_in,
  input wire logic [3:0] chan_refclk_out,
  // Data, core control and status
  input wire logic [63:0] tx_data_out,
  input wire logic core_reset_all_out,
  input wire logic [11:0] core_loopback_out,
  input wire logic [3:0] core_tx_polarity_out,
  input wire logic match_all_out,
  input wire logic error_latched_out
);
  logic [3:0] ref_exp;
  always_comb
    for (int c = 0; c < 4; c++)
      ref_exp[c] = refclk_p_in[REFSRC_SEL[c]] & ~refclk_n_in[REFSRC_SEL[c]];
  // The newest bit lands in bit 0, so the last 15 bits are the next state.
  function automatic logic [15:0] adv(input logic [14:0] s);
    for (int i = 15; i >= 0; i--) begin
      adv[i] = s[14] ^ s[13];
      s = {s[13:0], adv[i]};
    end
  endfunction
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_ref; chan_refclk_out == ref_exp; endproperty
  property p_set; $fell(match_all_out) && !core_reset_all_out |-> error_latched_out; endproperty
  property p_hold;
    (!error_clear_in && !full_system_reset_request_in)[*3] ##0 (error_latched_out && !core_reset_all_out)
      |=> error_latched_out;
  endproperty
  property p_clear; error_clear_in[*3] ##1 match_all_out[*2] |-> !error_latched_out; endproperty
  property p_busy_err; core_reset_all_out[*2] |-> !error_latched_out; endproperty
  property p_busy_tx; core_reset_all_out[*2] |-> tx_data_out == 64'h0; endproperty
  property p_req; $rose(full_system_reset_request_in) |-> ##[1:5] core_reset_all_out; endproperty
  property p_release; $fell(rst_in) |-> core_reset_all_out[*8] ##[7:11] !core_reset_all_out; endproperty
  property p_prbs; (!core_reset_all_out)[*3] |-> tx_data_out[15:0] == adv($past(tx_data_out[14:0])); endproperty
  property p_ties; core_loopback_out == 12'h0 && core_tx_polarity_out == 4'h0; endproperty
  a_ref: assert property (p_ref) else $error("reference clock routing wrong");
  a_set: assert property (p_set) else $error("sticky error not set");
  a_hold: assert property (p_hold) else $error("sticky error lost");
  a_clear: assert property (p_clear) else $error("sticky error not cleared");
  a_busy_err: assert property (p_busy_err) else $error("sticky error high in reset");
  a_busy_tx: assert property (p_busy_tx) else $error("pattern sent during reset");
  a_req: assert property (p_req) else $error("reset request ignored");
  a_release: assert property (p_release) else $error("reset sequence length wrong");
  a_prbs: assert property (p_prbs) else $error("pattern sequence wrong");
  a_ties: assert property (p_ties) else $error("unused core port not tied");
  c_set: cover property ($rose(error_latched_out));
  c_clear: cover property ($fell(error_latched_out));
  c_req: cover property ($rose(core_reset_all_out));
endmodule // pim_top_assertions
`default_nettype wire

/* dv/pim_loopback_model.sv */
// Loopback model of the transceiver channels, with one corruption control per channel.
`timescale 1ns/100ps
`default_nettype none
module pim_loopback_model (
  // Clock and core state
  input wire logic clk_in,
  input wire logic core_reset_all_in,
  // Transmit side and error injection
  input wire logic [63:0] tx_data_in,
  input wire logic [7:0] tx_header_in,
  input wire logic [3:0] corrupt_in,
  // Receive side
  output logic [63:0] rx_data_out,
  output logic [7:0] rx_header_out,
  output logic [3:0] rx_valid_out,
  output logic core_reset_done_out
);
  logic up_q = 1'b0;
  // Data and header lines carry no held value while the link is down, so they toggle instead.
  always @(posedge clk_in) begin
    up_q <= !core_reset_all_in;
    core_reset_done_out <= up_q;
    rx_valid_out <= {4{up_q}};
    rx_header_out <= up_q ? tx_header_in : ~rx_header_out;
    for (int c = 0; c < 4; c++)
      rx_data_out[c*16 +: 16] <= up_q ? tx_data_in[c*16 +: 16] ^ {15'h0, corrupt_in[c]} : ~rx_data_out[c*16 +: 16];
  end
endmodule // pim_loopback_model
`default_nettype wire

/* dv/pim_top_tb.sv */
// Self-checking testbench for the pattern integrity monitor top level.
`timescale 1ns/100ps
`default_nettype none
module pim_top_tb;
  localparam logic [3:0] SEL = 4'ha;
  // Channels 0 and 2 use the gearbox header, so both formats are exercised.
  localparam logic [3:0] ENC = 4'h5;
  logic clk_in = 1'b0, rst_in = 1'b1, full_system_reset_request_in = 1'b0, error_clear_in = 1'b0;
  logic [1:0] refclk_p_in = 2'h0, refclk_n_in = 2'h0;
  logic [3:0] chan_refclk_out, rx_valid_in, e, corrupt = 4'h0;
  logic [63:0] tx_data_out, rx_data_in;
  logic [7:0] tx_header_out, rx_header_in;
  logic core_reset_done_in, core_reset_all_out, match_all_out, error_latched_out;
  logic core_userclk_active_out, core_reset_done_out;
  int miscompares = 0, n_tests = 0, cyc = 0;
  initial forever #5 clk_in = ~clk_in;
  pim_top #(.ENC_MODE(ENC), .REFSRC_SEL(SEL)) u_pim_top (.clk_in, .rst_in, .full_system_reset_request_in,
    .error_clear_in, .refclk_p_in, .refclk_n_in, .chan_refclk_out, .tx_data_out, .tx_header_out, .rx_data_in,
    .rx_header_in, .rx_valid_in, .core_reset_done_in, .core_reset_all_out, .core_userclk_active_out,
    .core_loopback_out(), .core_tx_polarity_out(), .core_reset_done_out, .match_all_out, .error_latched_out);
  pim_loopback_model u_pim_loopback_model (.clk_in(clk_in), .core_reset_all_in(core_reset_all_out),
    .tx_data_in(tx_data_out), .tx_header_in(tx_header_out), .corrupt_in(corrupt), .rx_data_out(rx_data_in),
    .rx_header_out(rx_header_in), .rx_valid_out(rx_valid_in), .core_reset_done_out(core_reset_done_in));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_match(input logic v);
    int k = 0;
    while (match_all_out !== v && k < 40) begin
      tick(1);
      k++;
    end
    chk(match_all_out, v);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    tick(8);
    chk({match_all_out, error_latched_out}, 2'h0);
    rst_in = 1'b0;
    wait_match(1);
    chk({error_latched_out, tx_header_out}, 9'h011);
    chk({core_userclk_active_out, core_reset_done_out}, 2'h3);
    for (int c = 0; c < 4; c++) begin
      corrupt[c] = 1'b1;
      tick(1);
      corrupt[c] = 1'b0;
      wait_match(0);
      chk(error_latched_out, 1);
      wait_match(1);
      tick(3);
      chk(error_latched_out, 1);
      error_clear_in = 1'b1;
      tick(4);
      error_clear_in = 1'b0;
      chk(error_latched_out, 0);
    end
    // The clear reaches the flag in the very cycle of the set, and the set must win.
    corrupt = 4'h8;
    tick(1);
    corrupt = 4'h0;
    tick(1);
    error_clear_in = 1'b1;
    tick(1);
    error_clear_in = 1'b0;
    wait_match(0);
    chk(error_latched_out, 1);
    full_system_reset_request_in = 1'b1;
    tick(2);
    full_system_reset_request_in = 1'b0;
    tick(8);
    chk({core_reset_all_out, match_all_out, error_latched_out, core_userclk_active_out, core_reset_done_out},
      5'h10);
    wait_match(1);
    chk(error_latched_out, 0);
    chk({core_userclk_active_out, core_reset_done_out}, 2'h3);
    for (int v = 0; v < 16; v++) begin
      {refclk_p_in, refclk_n_in} = v[3:0];
      tick(1);
      for (int c = 0; c < 4; c++) e[c] = refclk_p_in[SEL[c]] & ~refclk_n_in[SEL[c]];
      chk(chan_refclk_out, e);
    end
    results();
  end
endmodule // pim_top_tb
bind pim_top pim_top_assertions #(.REFSRC_SEL(REFSRC_SEL)) u_pim_top_assertions (.clk_in, .rst_in,
  .full_system_reset_request_in, .error_clear_in, .refclk_p_in, .refclk_n_in, .chan_refclk_out, .tx_data_out,
  .core_reset_all_out, .core_loopback_out, .core_tx_polarity_out, .match_all_out, .error_latched_out);
`default_nettype wire
